// ### rtl/srtl_top.sv
// speed command ramp with sigmoid smoothing and torque limit clamp
`timescale 1ns/1ns
`default_nettype none
`include "srtl_map.svh"
module srtl_top
    import srtl_pkg::*;
#(
    parameter int          SAMPLE_CYCLES = `SRTL_SAMPLE_CYCLES,
    parameter logic [8:0]  SYS_MAX_TQ    = `SRTL_TQ_LIM_MAX,
    parameter logic [8:0]  TQ_LIM_RST    = `SRTL_TQ_LIM_RST
)(
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire logic               ctrl_power_up,
    input  wire logic signed [15:0] speed_target,
    input  wire logic signed [15:0] torque_demand,
    output logic signed [15:0]      speed_cmd_out,
    output logic signed [15:0]      torque_cmd_out
);
    localparam int STEP_CYCLES = `SRTL_STEP_CYCLES;

    srtl_aphase_t          aph_reg;
    srtl_settings_t        set_reg;
    logic                  sel_pend_reg;
    logic                  sel_act_reg;
    logic                  rej_reg;
    logic                  wr_now;
    logic                  rej_set;
    logic                  rej_clr;
    logic [31:0]           rd_next;

    logic [6:0]            step_cnt_reg;
    logic                  step_tick;
    logic [16:0]           samp_cnt_reg;
    logic                  samp_tick;
    logic signed [15:0]    lin_reg;
    logic [12:0]           acc_reg;
    logic                  accel_dir;
    logic [12:0]           time_set;

    srtl_state_t           st_reg;
    logic [8:0]            sig_n_reg;
    logic [8:0]            ptr_reg;
    logic signed [25:0]    sum_reg;
    logic signed [15:0]    smooth_reg;
    logic [15:0]           mem_rdata;
    logic                  mem_we;
    logic                  div_done;
    logic [25:0]           div_quot;
    logic [25:0]           sum_mag;

    logic [12:0]           lim_next;
    logic signed [15:0]    tq_next;

    function automatic logic [12:0] limit_counts(input logic [8:0] pct);
        logic [12:0] c;
        c = 13'(pct * `SRTL_TQ_SCALE);
        limit_counts = (c > `SRTL_TQ_PEAK) ? `SRTL_TQ_PEAK : c;
    endfunction

    function automatic logic signed [15:0] clamp_sym(
        input logic signed [15:0] v,
        input logic [12:0]        lim
    );
        logic signed [15:0] l;
        l = signed'({3'b000, lim});
        if (v > l)
            clamp_sym = l;
        else if (v < -l)
            clamp_sym = -l;
        else
            clamp_sym = v;
    endfunction

    // address phase capture; zero wait states, always OKAY
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            aph_reg <= '0;
        end
        else if (hready)
        begin
            aph_reg.valid <= hsel && htrans[1];
            aph_reg.write <= hwrite;
            aph_reg.addr  <= haddr[7:0];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign wr_now = aph_reg.valid && aph_reg.write;

    always_comb
    begin
        rd_next = 32'h0000_0000;
        case (haddr[7:0])
            `SRTL_OFS_ACCEL:   rd_next = {19'h0, set_reg.accel};
            `SRTL_OFS_DECEL:   rd_next = {19'h0, set_reg.decel};
            `SRTL_OFS_SIGMOID: rd_next = {23'h0, set_reg.sigmoid};
            `SRTL_OFS_TQ_LIM1: rd_next = {23'h0, set_reg.lim1};
            `SRTL_OFS_TQ_LIM2: rd_next = {23'h0, set_reg.lim2};
            `SRTL_OFS_TQ_SEL:  rd_next = {30'h0, sel_act_reg, sel_pend_reg};
            `SRTL_OFS_STATUS:  rd_next = {31'h0, rej_reg};
            `SRTL_OFS_SPEED:   rd_next = {{16{speed_cmd_out[15]}},
                                          speed_cmd_out};
            `SRTL_OFS_TORQUE:  rd_next = {{16{torque_cmd_out[15]}},
                                          torque_cmd_out};
            default:           rd_next = 32'h0000_0000;
        endcase
    end

    // read data registered at the address phase so it stands in the data phase
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            hrdata <= rd_next;
        end
    end

    // out-of-range writes leave the old value and raise the refusal flag
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            set_reg.accel   <= `SRTL_ACCEL_RST;               // [RULE1]
            set_reg.decel   <= `SRTL_ACCEL_RST;
            set_reg.sigmoid <= `SRTL_SIGMOID_RST;             // [RULE6]
            set_reg.lim1    <= TQ_LIM_RST;                    // [RULE12]
            set_reg.lim2    <= TQ_LIM_RST;                    // [RULE12]
        end
        else if (wr_now)
        begin
            case (aph_reg.addr)
                `SRTL_OFS_ACCEL:
                    if (hwdata <= 32'(`SRTL_ACCEL_MAX))
                        set_reg.accel <= hwdata[12:0];        // [RULE1]
                `SRTL_OFS_DECEL:
                    if (hwdata <= 32'(`SRTL_ACCEL_MAX))
                        set_reg.decel <= hwdata[12:0];
                `SRTL_OFS_SIGMOID:
                    if (hwdata <= 32'(`SRTL_SIGMOID_MAX))
                        set_reg.sigmoid <= hwdata[8:0];       // [RULE6]
                `SRTL_OFS_TQ_LIM1:
                    if (hwdata <= 32'(SYS_MAX_TQ))
                        set_reg.lim1 <= hwdata[8:0];          // [RULE7] [RULE11]
                `SRTL_OFS_TQ_LIM2:
                    if (hwdata <= 32'(SYS_MAX_TQ))
                        set_reg.lim2 <= hwdata[8:0];          // [RULE7] [RULE11]
                default:
                    ;
            endcase
        end
    end

    always_comb
    begin
        rej_set = 1'b0;
        if (wr_now)
        begin
            case (aph_reg.addr)
                `SRTL_OFS_ACCEL,
                `SRTL_OFS_DECEL:   rej_set = hwdata > 32'(`SRTL_ACCEL_MAX);
                `SRTL_OFS_SIGMOID: rej_set = hwdata > 32'(`SRTL_SIGMOID_MAX);
                `SRTL_OFS_TQ_LIM1,
                `SRTL_OFS_TQ_LIM2: rej_set = hwdata > 32'(SYS_MAX_TQ); // [RULE11]
                default:           rej_set = 1'b0;
            endcase
        end
    end

    assign rej_clr = wr_now && (aph_reg.addr == `SRTL_OFS_STATUS)
                     && hwdata[`SRTL_STATUS_REJ_BIT];

    // a refusal in the clearing cycle survives
    always_ff @(posedge core_clk)
    begin
        if (rst)
            rej_reg <= 1'b0;
        else if (rej_set)
            rej_reg <= 1'b1;
        else if (rej_clr)
            rej_reg <= 1'b0;
    end

    // limit select is a power-cycle setting: pending until power-up
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sel_pend_reg <= 1'b0;
            sel_act_reg  <= 1'b0;
        end
        else
        begin
            if (wr_now && aph_reg.addr == `SRTL_OFS_TQ_SEL)
                sel_pend_reg <= hwdata[0];
            if (ctrl_power_up)
                sel_act_reg <= sel_pend_reg;                  // [RULE13]
        end
    end

    // 2 us step enable: 1 r/min per step gives setting x 2 ms per 1000 r/min
    always_ff @(posedge core_clk)
    begin
        if (rst || step_tick)
            step_cnt_reg <= 7'h00;
        else
            step_cnt_reg <= step_cnt_reg + 7'h01;
    end
    assign step_tick = (step_cnt_reg == 7'(STEP_CYCLES - 1));

    always_ff @(posedge core_clk)
    begin
        if (rst || samp_tick)
            samp_cnt_reg <= 17'h00000;
        else
            samp_cnt_reg <= samp_cnt_reg + 17'h00001;
    end
    assign samp_tick = (samp_cnt_reg == 17'(SAMPLE_CYCLES - 1));

    // moving away from zero accelerates, toward zero decelerates
    assign accel_dir = (speed_target > lin_reg) ? (lin_reg >= 16'sh0000)
                                                : (lin_reg <= 16'sh0000);
    assign time_set  = accel_dir ? set_reg.accel : set_reg.decel;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            lin_reg <= 16'sh0000;
            acc_reg <= 13'h0000;
        end
        else if (speed_target == lin_reg)
        begin
            acc_reg <= 13'h0000;
        end
        else if (time_set == 13'h0000)
        begin
            lin_reg <= speed_target;                          // [RULE14] [RULE4]
            acc_reg <= 13'h0000;
        end
        else if (step_tick)
        begin
            if (acc_reg + 13'h0001 >= time_set)
            begin
                acc_reg <= 13'h0000;
                if (speed_target > lin_reg)
                    lin_reg <= lin_reg + 16'sh0001;           // [RULE2] [RULE3]
                else
                    lin_reg <= lin_reg - 16'sh0001;           // [RULE2] [RULE3]
            end
            else
            begin
                acc_reg <= acc_reg + 13'h0001;
            end
        end
    end

    // sigmoid: moving average of the linear ramp over sigmoid x 2 ms,
    // which rounds each corner over the window after it, lagging the ramp by half a window
    assign mem_we  = (st_reg == SM_FILL) || (st_reg == SM_UPD);
    assign sum_mag = sum_reg[25] ? 26'(-sum_reg) : 26'(sum_reg);

    srtl_mem #(
        .W  (16),
        .AW (9)
    ) u_mem (
        .clk   (core_clk),
        .we    (mem_we),
        .waddr (ptr_reg),
        .wdata (lin_reg),
        .raddr (ptr_reg),
        .rdata (mem_rdata)
    );

    srtl_div #(
        .NW (26),
        .DW (9)
    ) u_div (
        .clk   (core_clk),
        .rst   (rst),
        .start (st_reg == SM_DIVGO),
        .num   (sum_mag),
        .den   (sig_n_reg),
        .done  (div_done),
        .quot  (div_quot)
    );

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st_reg     <= SM_IDLE;
            sig_n_reg  <= 9'h000;
            ptr_reg    <= 9'h000;
            sum_reg    <= 26'sh0;
            smooth_reg <= 16'sh0000;
        end
        else
        begin
            case (st_reg)
                SM_IDLE:
                    if (set_reg.sigmoid != sig_n_reg)
                    begin
                        sig_n_reg <= set_reg.sigmoid;
                        ptr_reg   <= 9'h000;
                        sum_reg   <= 26'sh0;
                        if (set_reg.sigmoid != 9'h000)
                            st_reg <= SM_FILL;
                    end
                    else if (sig_n_reg != 9'h000 && samp_tick)
                        st_reg <= SM_READ;
                SM_FILL:
                begin
                    sum_reg <= sum_reg + 26'(lin_reg);
                    if (ptr_reg == sig_n_reg - 9'h001)
                    begin
                        ptr_reg <= 9'h000;
                        st_reg  <= SM_DIVGO;
                    end
                    else
                        ptr_reg <= ptr_reg + 9'h001;
                end
                SM_READ:
                    st_reg <= SM_UPD;
                SM_UPD:
                begin
                    sum_reg <= sum_reg + 26'(lin_reg)
                               - 26'(signed'(mem_rdata));     // [RULE5]
                    if (ptr_reg == sig_n_reg - 9'h001)
                        ptr_reg <= 9'h000;
                    else
                        ptr_reg <= ptr_reg + 9'h001;
                    st_reg <= SM_DIVGO;
                end
                SM_DIVGO:
                    st_reg <= SM_DIV;
                SM_DIV:
                    if (div_done)
                    begin
                        smooth_reg <= sum_reg[25] ? -16'(div_quot)
                                                  : 16'(div_quot);
                        st_reg     <= SM_IDLE;
                    end
                default:
                    st_reg <= SM_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            speed_cmd_out <= 16'sh0000;
        else if (sig_n_reg == 9'h000)
            speed_cmd_out <= lin_reg;
        else
            speed_cmd_out <= smooth_reg;                      // [RULE6]
    end

    // torque clamp: selected limit, never beyond the peak rating
    assign lim_next = limit_counts(sel_act_reg ? set_reg.lim2   // [RULE9]
                                               : set_reg.lim1);
    assign tq_next  = clamp_sym(torque_demand, lim_next);    // [RULE8] [RULE10]

    always_ff @(posedge core_clk)
    begin
        if (rst)
            torque_cmd_out <= 16'sh0000;
        else
            torque_cmd_out <= tq_next;
    end

    a_ramp_unit_step: assert property (@(posedge core_clk) disable iff (rst)
        (time_set != 13'h0000 && !step_tick && speed_target == $past(speed_target))
        |=> (lin_reg == $past(lin_reg)))                      // [RULE2]
        else $error("ramp moved outside a step enable");

    a_ramp_decel_hold: assert property (@(posedge core_clk) disable iff (rst)
        (set_reg.decel != 13'h0000 && !accel_dir && speed_target != lin_reg
         && acc_reg + 13'h0001 < time_set) |=> $stable(lin_reg)) // [RULE3]
        else $error("decel ramp stepped before its count");

    a_zero_pass: assert property (@(posedge core_clk) disable iff (rst)
        (time_set == 13'h0000) |=> (lin_reg == $past(speed_target))) // [RULE14]
        else $error("zero ramp setting did not pass target");

    a_accel_range: assert property (@(posedge core_clk) disable iff (rst)
        set_reg.accel <= `SRTL_ACCEL_MAX)                      // [RULE1]
        else $error("accel setting out of range");

    a_sig_bypass: assert property (@(posedge core_clk) disable iff (rst)
        (sig_n_reg == 9'h000) |=> (speed_cmd_out == $past(lin_reg))) // [RULE5]
        else $error("output not linear ramp with no smoothing");

    a_sig_window: assert property (@(posedge core_clk) disable iff (rst)
        (st_reg == SM_DIVGO) |-> ##[1:40] (st_reg == SM_IDLE)) // [RULE6]
        else $error("smoothing update did not finish");

    a_lim_bound: assert property (@(posedge core_clk) disable iff (rst)
        set_reg.lim1 <= SYS_MAX_TQ && set_reg.lim2 <= SYS_MAX_TQ) // [RULE11]
        else $error("torque limit above system maximum");

    a_lim_refuse: assert property (@(posedge core_clk) disable iff (rst)
        (wr_now && aph_reg.addr == `SRTL_OFS_TQ_LIM1 && hwdata > 32'(SYS_MAX_TQ))
        |=> ($stable(set_reg.lim1) && rej_reg))                // [RULE11]
        else $error("oversize limit write not refused");

    a_tq_symmetric: assert property (@(posedge core_clk) disable iff (rst)
        1'b1 |=> (torque_cmd_out <= signed'({3'b000, $past(lim_next)})
              && torque_cmd_out >= -signed'({3'b000, $past(lim_next)}))) // [RULE8]
        else $error("torque beyond active limit");

    a_tq_peak: assert property (@(posedge core_clk) disable iff (rst)
        torque_cmd_out <= 16'sh0bb8 && torque_cmd_out >= -16'sh0bb8) // [RULE10]
        else $error("torque beyond three times rated");

    a_sel_power: assert property (@(posedge core_clk) disable iff (rst)
        !ctrl_power_up |=> $stable(sel_act_reg))               // [RULE13]
        else $error("limit select changed without power-up");

    a_sel_pick: assert property (@(posedge core_clk) disable iff (rst)
        sel_act_reg |-> (lim_next == limit_counts(set_reg.lim2))) // [RULE9]
        else $error("second limit not used when selected");

    a_rst_limit: assert property (@(posedge core_clk)
        rst |=> (set_reg.lim1 == TQ_LIM_RST && set_reg.lim2 == TQ_LIM_RST)) // [RULE12]
        else $error("limit reset value wrong");

    // below the peak the limit is ten counts per percent
    a_range_pct: assert property (                            // [RULE7]
        @(posedge core_clk) disable iff (rst)
        (set_reg.lim1 <= 9'h12c) |-> (limit_counts(set_reg.lim1)
            == ({4'h0, set_reg.lim1} << 3) + ({4'h0, set_reg.lim1} << 1)))
        else $error("limit scaling wrong");
endmodule
`default_nettype wire

// ### rtl/srtl_map.svh
// offsets, field positions, reset values and timing counts of the ramp block
// Functional notes
// RULE1: ramp the speed command; acceleration setting 0..5000, reset value 0.
// RULE2: accelerating by 1000 r/min takes accel setting times 2 ms.
// RULE3: decelerating by 1000 r/min takes decel setting times 2 ms.
// RULE4: with an outer position loop the user sets both ramp settings to 0.
// RULE5: the smoothed curve is built on top of the linear ramp.
// RULE6: sigmoid setting 0..500 in 2 ms units; window centred on each corner. The code averages a trailing window, so rounding starts at the corner.
// RULE7: each torque limit is 0..500 percent of rated torque.
// RULE8: the active limit clamps torque equally in both directions.
// RULE9: a select setting picks the first or the second torque limit.
// RULE10: unlimited, torque may reach about three times rated torque.
// RULE11: a torque limit above the fixed system maximum is refused.
// RULE12: limits reset to 500, but the figure depends on motor and drive.
// RULE13: power-cycle settings take effect only at the next control power-up.
// RULE14: each control step moves the command toward target; zero passes it.
`ifndef SRTL_MAP_SVH
`define SRTL_MAP_SVH

`define SRTL_OFS_ACCEL      8'h00
`define SRTL_OFS_DECEL      8'h04
`define SRTL_OFS_SIGMOID    8'h08
`define SRTL_OFS_TQ_LIM1    8'h0c
`define SRTL_OFS_TQ_LIM2    8'h10
`define SRTL_OFS_TQ_SEL     8'h14
`define SRTL_OFS_STATUS     8'h18
`define SRTL_OFS_SPEED      8'h1c
`define SRTL_OFS_TORQUE     8'h20

`define SRTL_ACCEL_MAX      13'h1388
`define SRTL_SIGMOID_MAX    9'h1f4
`define SRTL_TQ_LIM_MAX     9'h1f4
`define SRTL_ACCEL_RST      13'h0000
`define SRTL_SIGMOID_RST    9'h000
`define SRTL_TQ_LIM_RST     9'h1f4
`define SRTL_TQ_PEAK        13'h0bb8
`define SRTL_TQ_SCALE       4'ha
`define SRTL_STATUS_REJ_BIT 0
`define SRTL_SEL_ACT_BIT    1

`define SRTL_CLK_MHZ        50
`define SRTL_STEP_NS        2000
`define SRTL_SAMPLE_US      2000
`define SRTL_STEP_CYCLES    ((`SRTL_STEP_NS * `SRTL_CLK_MHZ) / 1000)
`define SRTL_SAMPLE_CYCLES  (`SRTL_SAMPLE_US * `SRTL_CLK_MHZ)

`endif

// ### rtl/srtl_pkg.sv
// types shared by the speed ramp and torque limit block
package srtl_pkg;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
    } srtl_aphase_t;

    typedef struct packed {
        logic [12:0] accel;
        logic [12:0] decel;
        logic [8:0]  sigmoid;
        logic [8:0]  lim1;
        logic [8:0]  lim2;
    } srtl_settings_t;

    typedef enum logic [2:0] {
        SM_IDLE,
        SM_FILL,
        SM_READ,
        SM_UPD,
        SM_DIVGO,
        SM_DIV
    } srtl_state_t;
endpackage

// ### rtl/srtl_mem.sv
// window memory of past ramp samples with registered read data
`timescale 1ns/1ns
`default_nettype none
module srtl_mem
    import srtl_pkg::*;
#(
    parameter int W  = 16,
    parameter int AW = 9
)(
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata
);
    logic [W-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// ### rtl/srtl_div.sv
// serial restoring divider, one quotient bit per clock
`timescale 1ns/1ns
`default_nettype none
module srtl_div
    import srtl_pkg::*;
#(
    parameter int NW = 26,
    parameter int DW = 9
)(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          start,
    input  wire logic [NW-1:0] num,
    input  wire logic [DW-1:0] den,
    output logic               done,
    output logic      [NW-1:0] quot
);
    logic [DW:0]     rem_reg;
    logic [NW-1:0]   q_reg;
    logic [DW-1:0]   den_reg;
    logic [5:0]      cnt_reg;
    logic [DW:0]     trial;

    assign trial = {rem_reg[DW-1:0], q_reg[NW-1]};

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rem_reg <= '0;
            q_reg   <= '0;
            den_reg <= '0;
            cnt_reg <= '0;
            done    <= 1'b0;
            quot    <= '0;
        end
        else if (start)
        begin
            rem_reg <= '0;
            q_reg   <= num;
            den_reg <= den;
            cnt_reg <= 6'(NW);
            done    <= 1'b0;
        end
        else if (cnt_reg != 6'h00)
        begin
            if (trial >= {1'b0, den_reg})
            begin
                rem_reg <= trial - {1'b0, den_reg};
                q_reg   <= {q_reg[NW-2:0], 1'b1};
            end
            else
            begin
                rem_reg <= trial;
                q_reg   <= {q_reg[NW-2:0], 1'b0};
            end
            cnt_reg <= cnt_reg - 6'h01;
            done    <= (cnt_reg == 6'h01);
            if (cnt_reg == 6'h01)
            begin
                quot <= {q_reg[NW-2:0], (trial >= {1'b0, den_reg})};
            end
        end
        else
        begin
            done <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### verif/srtl_src.sv
// far-side model: speed command source and torque loop input
`timescale 1ns/1ns
`default_nettype none
module srtl_src
(
    input  wire logic               clk,
    input  wire logic signed [15:0] spd_set,
    input  wire logic signed [15:0] tq_set,
    output logic signed [15:0]      speed_target,
    output logic signed [15:0]      torque_demand
);
    // a controller changes its commands only at clock edges
    always_ff @(posedge clk)
    begin
        speed_target  <= spd_set;
        torque_demand <= tq_set;
    end
endmodule
`default_nettype wire

// ### verif/tb.sv
// self-checking bench of the speed ramp and torque limit block
`timescale 1ns/1ns
`default_nettype none
`include "srtl_map.svh"
module tb import srtl_pkg::*;;
    logic               core_clk = 0, rst = 1, hwrite = 0, pwr = 0;
    logic               hsel = 1;
    logic        [31:0] haddr = 0, hwdata = 0, rd;
    logic        [1:0]  htrans = 0;
    logic        [2:0]  hsize = 3'h2;
    logic signed [15:0] spd = 0, tqd = 0, v0;
    wire logic   [31:0] hrdata;
    wire logic          hreadyout, hresp;
    wire logic signed [15:0] st, td, sco, tco;
    int miscompares = 0, samples_checked = 0, cyc = 0, l1, l2, m;
    srtl_src src (.clk(core_clk), .spd_set(spd), .tq_set(tqd),
        .speed_target(st), .torque_demand(td));
    srtl_top #(.SAMPLE_CYCLES(200)) dut (.core_clk(core_clk), .rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ctrl_power_up(pwr), .speed_target(st), .torque_demand(td),
        .speed_cmd_out(sco), .torque_cmd_out(tco));
    initial
    begin
        forever #10 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rd = hrdata;
        chk(hresp, 0);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(0, a, 0);
        chk(rd, e);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // expected clamp: limit in percent, torque in 0.1 percent steps
    function automatic logic signed [15:0] tq(input int d, input int l);
        int k;
        k = (l * 10 > 3000) ? 3000 : l * 10;
        return (d > k) ? k : (d < -k) ? -k : d;
    endfunction
    // measure ramp slope over 2000 clocks; one step per set*100 clocks
    task automatic ramp(input logic signed [15:0] tgt, input int e);
        v0 = sco;
        spd <= tgt;
        wait_n(2000);
        m = sco - v0;
        chk(m >= e - 1 && m <= e + 1, 1);
    endtask
    task automatic wrap_up;
        $display("checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            miscompares++;
            wrap_up();
        end
    end
    initial
    begin
        void'($urandom(32'he6363307));
        wait_n(20);
        rst <= 0;
        wait_n(2);
        rdchk(`SRTL_OFS_ACCEL, 0);
        rdchk(`SRTL_OFS_SIGMOID, 0);
        rdchk(`SRTL_OFS_TQ_LIM2, 500);
        bus(1, `SRTL_OFS_ACCEL, 5001);
        rdchk(`SRTL_OFS_ACCEL, 0);
        bus(1, `SRTL_OFS_TQ_LIM1, 501);
        rdchk(`SRTL_OFS_TQ_LIM1, 500);
        rdchk(`SRTL_OFS_STATUS, 1);
        bus(1, `SRTL_OFS_STATUS, 1);
        rdchk(`SRTL_OFS_STATUS, 0);
        rdchk(8'h40, 0);
        $display("test reset_refuse done");
        for (int i = 0; i < 8; i++)
        begin
            l1 = (i == 0) ? 0 : (i == 1) ? 500 : $urandom_range(500, 0);
            l2 = $urandom_range(500, 0);
            bus(1, `SRTL_OFS_TQ_LIM1, l1);
            bus(1, `SRTL_OFS_TQ_LIM2, l2);
            bus(1, `SRTL_OFS_TQ_SEL, i & 1);
            rdchk(`SRTL_OFS_TQ_SEL, {(i > 0) && !i[0], i[0]});
            pwr <= 1;
            wait_n(1);
            pwr <= 0;
            rdchk(`SRTL_OFS_TQ_SEL, {i[0], i[0]});
            for (int j = 0; j < 6; j++)
            begin
                m = (j < 2) ? (j ? -32767 : 32767)
                    : $urandom_range(8000, 0) - 4000;
                tqd <= m;
                wait_n(3);
                chk(tco, tq(m, i[0] ? l2 : l1));
            end
        end
        $display("test torque done");
        // outer-loop use: both ramps off, command passes straight through
        spd <= 16'sd1234;
        wait_n(4);
        chk(sco, 16'sd1234);
        bus(1, `SRTL_OFS_ACCEL, 1);
        bus(1, `SRTL_OFS_DECEL, 2);
        ramp(16'sd2000, 20);
        ramp(-16'sd0, -10);
        bus(1, `SRTL_OFS_ACCEL, 0);
        bus(1, `SRTL_OFS_DECEL, 0);
        spd <= -16'sd300;
        wait_n(4);
        chk(sco, -16'sd300);
        rdchk(`SRTL_OFS_SPEED, -300);
        // four-sample window: a step only shows once the window has moved
        bus(1, `SRTL_OFS_SIGMOID, 4);
        wait_n(40);
        chk(sco, -16'sd300);
        spd <= 16'sd500;
        wait_n(4);
        chk(sco, -16'sd300);
        wait_n(1200);
        chk(sco, 16'sd500);
        $display("test ramp done");
        wrap_up();
    end
endmodule
`default_nettype wire
